// file: ecs_cap_bank.sv
// Capability structure bank: PM, MSI, PCIe, AER and serial number.
// Assumes APB master on mclk and a config request port from the link core.
//
// What this block does
// R01: Next pointer resets to zero, no user caps
// R02: Non-zero pointer disables terminate-all
// R03: PCIe capability version resets to two
// R04: Retry buffer never smaller than 512B
// R05: Config value fills device caps bits 27:3
// R06: Relaxed ordering only changes capability bit
// R07: User transmitter enforces strict ordering itself
// R08: Link capability advertises configured maximum width
// R09: Config value fills device caps 2 bits 4:0
// R10: Granted message count shown on output port
// R11: AER capability reports version one
// R12: Serial number capability reports version one
// R13: Serial capability returns configured 64-bit value
// R14: PM capabilities upper half from config
// R15: PM structure reports configured data scale
// R16: Four configured consumed figures, eight bits each
// R17: Four configured dissipated figures, eight bits each
// R18: Terminate-all completes every config request
// R19: User services requests to its own caps
`timescale 1ns/1ps
`default_nettype none
module ecs_cap_bank
    import ecs_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Config requests from the link core
    input  wire logic        cfg_req,
    input  wire logic        cfg_wr,
    input  wire logic [9:0]  cfg_idx,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_cpl,
    output logic      [31:0] cfg_cpl_data,
    // Forward to user logic
    output logic             usr_cfg_req,
    output logic             usr_cfg_wr,
    output logic      [9:0]  usr_cfg_idx,
    output logic      [31:0] usr_cfg_wdata,
    // Status to user and data link layer
    output logic      [2:0]  msi_granted_count,
    output logic      [2:0]  retry_buf_code
);
    // ------------------------------------------------------------
    // Software settings
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [24:0] devcap_r;
    logic [4:0]  devcap2_r;
    logic [31:0] dsn_lo_r;
    logic [31:0] dsn_hi_r;
    logic [17:0] pmc_r;
    logic [31:0] cons_r;
    logic [31:0] diss_r;
    // Config space state written by the root complex, plus registered grant and retry status
    logic [3:0]  pm_sel_r;
    logic [1:0]  pm_state_r;
    logic        msi_en_r;
    logic [2:0]  msi_mme_r;
    logic        ro_en_r;
    logic [2:0]  grant_r;
    logic [2:0]  retry_r;

    // Field views of the control register
    wire [7:0] next_ptr_w  = ctrl_r[CTRL_PTR_LSB +: 8];
    wire       term_set_w  = ctrl_r[CTRL_TERM];
    wire       relax_w     = ctrl_r[CTRL_RELAX];
    wire [3:0] cap_ver_w   = ctrl_r[CTRL_VER_LSB +: 4];
    wire [2:0] mps_w       = ctrl_r[CTRL_MPS_LSB +: 3];
    wire [5:0] lwidth_w    = ctrl_r[CTRL_LW_LSB +: 6];
    wire [2:0] msi_req_w   = ctrl_r[CTRL_MSI_LSB +: 3];
    // Terminate-all only takes effect with no user capability chain
    wire       term_eff_w  = term_set_w && (next_ptr_w == 8'h00); // [R02]

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire       setup_w  = psel && !penable;
    wire       acc_w    = psel && penable && pready;
    wire       wr_acc_w = acc_w && pwrite;
    wire [7:0] a_w      = paddr;
    wire       hit_w    = (a_w[1:0] == 2'b00) && (a_w <= REG_STATUS);
    wire [31:0] status_w = {24'h00_0000, msi_en_r, retry_r, term_eff_w, grant_r};
    logic [31:0] rd_mux_w;
    always_comb begin
        rd_mux_w = 32'h0000_0000;
        case (a_w)
            REG_CTRL:     rd_mux_w = ctrl_r;
            REG_DEVCAP:   rd_mux_w = {7'h00, devcap_r};
            REG_DEVCAP2:  rd_mux_w = {27'h000_0000, devcap2_r};
            REG_DSN_LO:   rd_mux_w = dsn_lo_r;
            REG_DSN_HI:   rd_mux_w = dsn_hi_r;
            REG_PMC:      rd_mux_w = {14'h0000, pmc_r};
            REG_PWR_CONS: rd_mux_w = cons_r;
            REG_PWR_DISS: rd_mux_w = diss_r;
            REG_STATUS:   rd_mux_w = status_w;
            default:      rd_mux_w = 32'h0000_0000;
        endcase
    end

    // Answer one cycle after setup; read data latched at setup
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_w;
            pslverr <= setup_w && !hit_w;
            if (setup_w) prdata <= rd_mux_w;
        end
    end

    // Register writes take effect at the access edge
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrl_r    <= {6'h00, MSI_REQ_RST, LW_RST, MPS_RST, PCIE_VER_RST,
                          1'b1, 1'b0, PTR_RST}; // [R01] [R03]
            devcap_r  <= 25'h000_0000;
            devcap2_r <= DEVCAP2_RST;
            dsn_lo_r  <= 32'h0000_0000;
            dsn_hi_r  <= 32'h0000_0000;
            pmc_r     <= {2'b00, PMC_HI_RST};
            cons_r    <= 32'h0000_0000;
            diss_r    <= 32'h0000_0000;
        end else if (wr_acc_w) begin
            case (a_w)
                REG_CTRL:     ctrl_r    <= pwdata;
                REG_DEVCAP:   devcap_r  <= pwdata[24:0];
                REG_DEVCAP2:  devcap2_r <= pwdata[4:0];
                REG_DSN_LO:   dsn_lo_r  <= pwdata;
                REG_DSN_HI:   dsn_hi_r  <= pwdata;
                REG_PMC:      pmc_r     <= pwdata[17:0];
                REG_PWR_CONS: cons_r    <= pwdata;
                REG_PWR_DISS: diss_r    <= pwdata;
                default:      ctrl_r    <= ctrl_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Capability words
    // ------------------------------------------------------------
    logic [7:0] pwr_data_w;
    ecs_pwr_sel u_pwr (
        .pwr_cons (cons_r),
        .pwr_diss (diss_r),
        .data_sel (pm_sel_r),
        .pwr_data (pwr_data_w)
    );

    // Word values presented in config space
    wire [31:0] pm_cap_w   = {pmc_r[15:0], PTR_MSI, ID_PM}; // [R14]
    wire [31:0] pm_csr_w   = {pwr_data_w, 9'h000, pmc_r[17:16], pm_sel_r,
                              7'h00, pm_state_r}; // [R15] [R16] [R17]
    wire [31:0] msi_cap_w  = {9'h000, msi_mme_r, msi_req_w, msi_en_r, PTR_PCIE, ID_MSI};
    wire [31:0] pcie_cap_w = {12'h000, cap_ver_w, next_ptr_w, ID_PCIE}; // [R01] [R03]
    wire [2:0]  mps_cap_w  = mps_w;
    wire [31:0] devcap_w   = {4'h0, devcap_r, mps_cap_w}; // [R05]
    wire [31:0] devctl_w   = {27'h000_0000, ro_en_r, 4'h0};
    wire [31:0] linkcap_w  = {22'h00_0000, lwidth_w, 4'h1}; // [R08]
    wire [31:0] devcap2_w  = {27'h000_0000, devcap2_r}; // [R09]
    wire [31:0] aer_hdr_w  = {PTR_DSN, AER_VER, ID_AER}; // [R11]
    wire [31:0] dsn_hdr_w  = {12'h000, DSN_VER, ID_DSN}; // [R12]

    // Config read mux and claim decode
    logic [31:0] cfg_mux_w;
    logic        claim_w;
    always_comb begin
        cfg_mux_w = 32'h0000_0000;
        claim_w   = 1'b1;
        case (cfg_idx)
            IDX_PM_CAP:   cfg_mux_w = pm_cap_w;
            IDX_PM_CSR:   cfg_mux_w = pm_csr_w;
            IDX_MSI_CAP:  cfg_mux_w = msi_cap_w;
            IDX_PCIE_CAP: cfg_mux_w = pcie_cap_w;
            IDX_DEVCAP:   cfg_mux_w = devcap_w;
            IDX_DEVCTL:   cfg_mux_w = devctl_w;
            IDX_LINKCAP:  cfg_mux_w = linkcap_w;
            IDX_DEVCAP2:  cfg_mux_w = devcap2_w;
            IDX_AER_HDR:  cfg_mux_w = aer_hdr_w;
            IDX_DSN_HDR:  cfg_mux_w = dsn_hdr_w;
            IDX_DSN_LO:   cfg_mux_w = dsn_lo_r; // [R13]
            IDX_DSN_HI:   cfg_mux_w = dsn_hi_r; // [R13]
            default:      claim_w   = 1'b0;
        endcase
    end

    // Complete locally when claimed or in terminate-all mode
    wire do_cpl_w = cfg_req && (claim_w || term_eff_w); // [R18]
    // Unclaimed requests go to the user chain unless terminate-all is in effect
    wire do_fwd_w = cfg_req && !claim_w && !term_eff_w; // [R19]
    wire cfg_wr_w = cfg_req && cfg_wr && claim_w;

    ecs_cpl_reg u_cpl (
        .mclk          (mclk),
        .rst_b         (rst_b),
        .do_cpl        (do_cpl_w),
        .do_fwd        (do_fwd_w),
        .cpl_data      (cfg_wr ? 32'h0000_0000 : cfg_mux_w),
        .req_wr        (cfg_wr),
        .req_idx       (cfg_idx),
        .req_wdata     (cfg_wdata),
        .cfg_cpl       (cfg_cpl),
        .cfg_cpl_data  (cfg_cpl_data),
        .usr_cfg_req   (usr_cfg_req),
        .usr_cfg_wr    (usr_cfg_wr),
        .usr_cfg_idx   (usr_cfg_idx),
        .usr_cfg_wdata (usr_cfg_wdata)
    );

    // ------------------------------------------------------------
    // Root complex writable fields and derived outputs
    // ------------------------------------------------------------
    // Granted count never exceeds the requested count
    wire [2:0] grant_nxt = (msi_mme_r > msi_req_w) ? msi_req_w : msi_mme_r;
    // Payloads of 128B and 256B share the 512B retry buffer
    wire [2:0] retry_nxt = (mps_w < MPS_512) ? 3'h0 : 3'(mps_w - MPS_512);

    // Config writes to PMCSR, MSI control and device control
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pm_sel_r   <= 4'h0;
            pm_state_r <= 2'b00;
            msi_en_r   <= 1'b0;
            msi_mme_r  <= 3'h0;
            ro_en_r    <= 1'b0;
        end else if (cfg_wr_w) begin
            if (cfg_idx == IDX_PM_CSR) begin
                pm_sel_r   <= cfg_wdata[12:9];
                pm_state_r <= cfg_wdata[1:0];
            end
            if (cfg_idx == IDX_MSI_CAP) begin
                msi_en_r  <= cfg_wdata[16];
                msi_mme_r <= cfg_wdata[22:20];
            end
            // Stored bit only; transaction handling is untouched
            if (cfg_idx == IDX_DEVCTL) ro_en_r <= cfg_wdata[4] && relax_w; // [R06] [R07]
        end
    end

    // Registered status outputs
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            grant_r <= 3'h0;
            retry_r <= 3'h0;
        end else begin
            grant_r <= grant_nxt; // [R10]
            retry_r <= retry_nxt; // [R04]
        end
    end
    assign msi_granted_count = grant_r;
    assign retry_buf_code    = retry_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    term_block_a: assert property (cfg_req && next_ptr_w != 8'h00 && !claim_w // [R02]
                                   |=> usr_cfg_req)
        else $error("Forward missing with user pointer set");
    term_all_a: assert property (cfg_req && term_eff_w |=> cfg_cpl && !usr_cfg_req) // [R18]
        else $error("Terminate-all forwarded a request");
    retry_min_a: assert property (mps_w < MPS_512 |=> retry_buf_code == 3'h0) // [R04]
        else $error("Retry buffer below 512B");
    devcap_bits_a: assert property (cfg_req && !cfg_wr && cfg_idx == IDX_DEVCAP // [R05]
                                    |=> cfg_cpl_data[27:3] == $past(devcap_r))
        else $error("Device caps bits wrong");
    devcap2_bits_a: assert property (cfg_req && !cfg_wr && cfg_idx == IDX_DEVCAP2 // [R09]
                                     |=> cfg_cpl_data[4:0] == $past(devcap2_r))
        else $error("Device caps 2 bits wrong");
    aer_ver_a: assert property (cfg_req && !cfg_wr && cfg_idx == IDX_AER_HDR // [R11]
                                |=> cfg_cpl_data[19:16] == 4'h1)
        else $error("AER version not one");
    dsn_ver_a: assert property (cfg_req && !cfg_wr && cfg_idx == IDX_DSN_HDR // [R12]
                                |=> cfg_cpl_data[19:16] == 4'h1)
        else $error("Serial version not one");
    dsn_value_a: assert property (cfg_req && !cfg_wr && cfg_idx == IDX_DSN_HI // [R13]
                                  |=> cfg_cpl_data == $past(dsn_hi_r))
        else $error("Serial high word wrong");
    grant_cnt_a: assert property (##1 msi_granted_count <= $past(msi_req_w)) // [R10]
        else $error("Granted count above request");
    pmc_hi_a: assert property (cfg_req && !cfg_wr && cfg_idx == IDX_PM_CAP // [R14]
                               |=> cfg_cpl_data[31:16] == $past(pmc_r[15:0]))
        else $error("PM capabilities upper half wrong");
    pwr_fig_a: assert property ( // [R15] [R16] [R17]
                                cfg_req && !cfg_wr && cfg_idx == IDX_PM_CSR && pm_sel_r == 4'h5
                                |=> cfg_cpl_data[31:24] == $past(diss_r[15:8]))
        else $error("Power figure wrong");
    link_w_a: assert property (cfg_req && !cfg_wr && cfg_idx == IDX_LINKCAP // [R08]
                               |=> cfg_cpl_data[9:4] == $past(lwidth_w))
        else $error("Link width wrong");
    apb_ans_a: assert property (setup_w |=> pready ##1 !pready)
        else $error("APB answer not one cycle");

    cov_fwd_c:  cover property (cfg_req && do_fwd_w ##1 usr_cfg_req);
    cov_term_c: cover property (cfg_req && term_eff_w && !claim_w ##1 cfg_cpl);
    cov_msi_c:  cover property (cfg_wr_w && cfg_idx == IDX_MSI_CAP ##2 msi_granted_count != 3'h0);
    cov_err_c:  cover property (pready && pslverr);
endmodule
`default_nettype wire

// file: ecs_cap_bank_tb_top.sv
// Testbench for the capability bank: APB register tasks and config requests.
// Assumes the root complex model drives the config port.
`timescale 1ns/1ps
`default_nettype none
module ecs_cap_bank_tb_top
    import ecs_pkg::*;
;
    logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, cfg_req, cfg_wr, cfg_cpl;
    logic        usr_cfg_req, usr_cfg_wr;
    logic [7:0]  paddr, pw;
    logic [31:0] pwdata, prdata, cfg_wdata, cfg_cpl_data, usr_cfg_wdata, q;
    logic [9:0]  cfg_idx, usr_cfg_idx;
    logic [2:0]  msi_granted_count, retry_buf_code;
    logic        c, f, e;
    int          n_errors, n_tests;
    ecs_cap_bank ecs_cap_bank_inst (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cfg_req, .cfg_wr, .cfg_idx, .cfg_wdata, .cfg_cpl,
        .cfg_cpl_data, .usr_cfg_req, .usr_cfg_wr, .usr_cfg_idx, .usr_cfg_wdata,
        .msi_granted_count, .retry_buf_code);
    ecs_rc_model ecs_rc_model_inst (.mclk, .cfg_req, .cfg_wr, .cfg_idx, .cfg_wdata, .cfg_cpl,
        .cfg_cpl_data, .usr_cfg_req);
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // APB master and config request helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Read, then compare data and the error flag of unmapped places
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, ex);
        chk({31'h0, e}, {31'h0, (a > REG_STATUS || a[1:0] != 2'b00)});
    endtask
    task automatic cf(input logic w, input logic [9:0] i, input logic [31:0] d, input logic ef,
                      input logic [31:0] ex);
        ecs_rc_model_inst.access(w, i, d, c, f, q);
        if (c !== 1'b1 && f !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        chk({30'h0, c, f}, {30'h0, ~ef, ef});
        if (ef) begin
            chk({22'h0, usr_cfg_idx}, {22'h0, i});
            chk(usr_cfg_wdata, d);
            chk({31'h0, usr_cfg_wr}, {31'h0, w});
        end else begin
            chk(q, ex);
        end
    endtask
    function automatic logic [31:0] ctl(logic [7:0] p, logic t, logic r, int m, int w, int k);
        return 32'(p) | 32'(t) << CTRL_TERM | 32'(r) << CTRL_RELAX | 32'h2 << CTRL_VER_LSB
             | 32'(m) << CTRL_MPS_LSB | 32'(w) << CTRL_LW_LSB | 32'(k) << CTRL_MSI_LSB;
    endfunction
    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        n_tests = 0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        rd(REG_CTRL, ctl(8'h00, 1'b0, 1'b1, 0, 1, 0));
        rd(REG_DEVCAP2, 32'h0000_0011);
        rd(REG_PMC, 32'h0000_0003);
        rd(8'h24, 32'h0000_0000);
        rd(8'h06, 32'h0000_0000);
        cf(1'b0, IDX_PCIE_CAP, 0, 1'b0, {12'h000, 4'h2, 8'h00, ID_PCIE});
        cf(1'b0, IDX_AER_HDR, 0, 1'b0, {PTR_DSN, 4'h1, ID_AER});
        cf(1'b0, IDX_DSN_HDR, 0, 1'b0, {12'h000, 4'h1, ID_DSN});
        // Loose configuration values reach config space
        wr(REG_DEVCAP, 32'h01AB_CDEF);
        cf(1'b0, IDX_DEVCAP, 0, 1'b0, 32'h01AB_CDEF << 3);
        wr(REG_DEVCAP2, 32'hFFFF_FFFF);
        cf(1'b0, IDX_DEVCAP2, 0, 1'b0, 32'h0000_001F);
        wr(REG_DSN_LO, 32'h1234_5678);
        wr(REG_DSN_HI, 32'h9ABC_DEF0);
        cf(1'b0, IDX_DSN_LO, 0, 1'b0, 32'h1234_5678);
        cf(1'b0, IDX_DSN_HI, 0, 1'b0, 32'h9ABC_DEF0);
        wr(REG_PMC, 32'h0002_ABCD);
        cf(1'b0, IDX_PM_CAP, 0, 1'b0, {16'hABCD, PTR_MSI, ID_PM});
        wr(REG_PWR_CONS, 32'h4433_2211);
        wr(REG_PWR_DISS, 32'h8877_6655);
        // Data selects 0 to 9, including two unused ones
        for (int s = 0; s < 10; s++) begin
            pw = (s < 8) ? 8'(64'h8877_6655_4433_2211 >> (8 * s)) : 8'h00;
            cf(1'b1, IDX_PM_CSR, 32'(s) << 9, 1'b0, 32'h0000_0000);
            cf(1'b0, IDX_PM_CSR, 0, 1'b0, {pw, 9'h000, 2'h2, 4'(s), 9'h000});
        end
        // Every payload size and a range of link widths
        for (int m = 0; m < 6; m++) begin
            wr(REG_CTRL, ctl(8'h00, 1'b0, 1'b1, m, m + 1, 0));
            rd(REG_STATUS, 32'(m > 2 ? m - 2 : 0) << 4);
            chk({29'h0, retry_buf_code}, 32'(m > 2 ? m - 2 : 0));
            cf(1'b0, IDX_LINKCAP, 0, 1'b0, 32'(m + 1) << 4 | 32'h0000_0001);
        end
        // Relaxed ordering only gates its own capability bit
        for (int r = 0; r < 2; r++) begin
            wr(REG_CTRL, ctl(8'h00, 1'b0, 1'(r), 0, 1, 0));
            cf(1'b1, IDX_DEVCTL, 32'h0000_0010, 1'b0, 32'h0000_0000);
            ecs_rc_model_inst.access(1'b0, IDX_DEVCTL, 0, c, f, q);
            chk(q & 32'h0000_0010, 32'(r) << 4);
        end
        // Granted count is the smaller of request and grant
        wr(REG_CTRL, ctl(8'h00, 1'b0, 1'b1, 0, 1, 3));
        for (int g = 2; g < 6; g += 3) begin
            cf(1'b1, IDX_MSI_CAP, 32'(g) << 20, 1'b0, 32'h0000_0000);
            repeat (2) @(posedge mclk);
            #1;
            chk({29'h0, msi_granted_count}, (g < 3) ? 32'(g) : 32'h3);
        end
        // Terminate-all, then overridden by a user pointer
        wr(REG_CTRL, ctl(8'h00, 1'b1, 1'b1, 0, 1, 0));
        rd(REG_STATUS, 32'h0000_0008);
        cf(1'b0, 10'h060, 0, 1'b0, 32'h0000_0000);
        cf(1'b1, 10'h3F0, 32'h5A5A_A5A5, 1'b0, 32'h0000_0000);
        wr(REG_CTRL, ctl(8'h80, 1'b1, 1'b1, 0, 1, 0));
        rd(REG_STATUS, 32'h0000_0000);
        cf(1'b0, IDX_PCIE_CAP, 0, 1'b0, {12'h000, 4'h2, 8'h80, ID_PCIE});
        cf(1'b0, 10'h060, 0, 1'b1, 32'h0000_0000);
        cf(1'b1, 10'h061, 32'hA5A5_5A5A, 1'b1, 32'h0000_0000);
        end_of_test();
    end
endmodule
`default_nettype wire

// file: ecs_cpl_reg.sv
// Output stage for config completions and user forwards.
// Assumes one request per cycle at most, on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ecs_cpl_reg
    import ecs_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Decided request
    input  wire logic        do_cpl,
    input  wire logic        do_fwd,
    input  wire logic [31:0] cpl_data,
    input  wire logic        req_wr,
    input  wire logic [9:0]  req_idx,
    input  wire logic [31:0] req_wdata,
    // Registered outputs
    output logic             cfg_cpl,
    output logic      [31:0] cfg_cpl_data,
    output logic             usr_cfg_req,
    output logic             usr_cfg_wr,
    output logic      [9:0]  usr_cfg_idx,
    output logic      [31:0] usr_cfg_wdata
);
    // Pulses and their payloads, one cycle after the request
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfg_cpl       <= 1'b0;
            cfg_cpl_data  <= 32'h0000_0000;
            usr_cfg_req   <= 1'b0;
            usr_cfg_wr    <= 1'b0;
            usr_cfg_idx   <= 10'h000;
            usr_cfg_wdata <= 32'h0000_0000;
        end else begin
            cfg_cpl       <= do_cpl;
            usr_cfg_req   <= do_fwd;
            if (do_cpl) cfg_cpl_data <= cpl_data;
            if (do_fwd) begin
                usr_cfg_wr    <= req_wr;
                usr_cfg_idx   <= req_idx;
                usr_cfg_wdata <= req_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// file: ecs_pkg.sv
// Constants for the endpoint capability structure bank.
// Assumes a 32-bit APB register bus and a dword-indexed config request port.
package ecs_pkg;
    // ------------------------------------------------------------
    // APB register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DEVCAP   = 8'h04;
    localparam logic [7:0] REG_DEVCAP2  = 8'h08;
    localparam logic [7:0] REG_DSN_LO   = 8'h0C;
    localparam logic [7:0] REG_DSN_HI   = 8'h10;
    localparam logic [7:0] REG_PMC      = 8'h14;
    localparam logic [7:0] REG_PWR_CONS = 8'h18;
    localparam logic [7:0] REG_PWR_DISS = 8'h1C;
    localparam logic [7:0] REG_STATUS   = 8'h20;
    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int CTRL_PTR_LSB  = 0;
    localparam int CTRL_TERM     = 8;
    localparam int CTRL_RELAX    = 9;
    localparam int CTRL_VER_LSB  = 10;
    localparam int CTRL_MPS_LSB  = 14;
    localparam int CTRL_LW_LSB   = 17;
    localparam int CTRL_MSI_LSB  = 23;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  PTR_RST      = 8'h00;
    localparam logic [3:0]  PCIE_VER_RST = 4'h2;
    localparam logic [2:0]  MPS_RST      = 3'h0;
    localparam logic [5:0]  LW_RST       = 6'h01;
    localparam logic [2:0]  MSI_REQ_RST  = 3'h0;
    localparam logic [15:0] PMC_HI_RST   = 16'h0003;
    localparam logic [4:0]  DEVCAP2_RST  = 5'h11;
    localparam logic [3:0]  AER_VER      = 4'h1;
    localparam logic [3:0]  DSN_VER      = 4'h1;
    // ------------------------------------------------------------
    // Config space dword indices and capability ids
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PM_CAP   = 10'h010;
    localparam logic [9:0] IDX_PM_CSR   = 10'h011;
    localparam logic [9:0] IDX_MSI_CAP  = 10'h014;
    localparam logic [9:0] IDX_PCIE_CAP = 10'h01C;
    localparam logic [9:0] IDX_DEVCAP   = 10'h01D;
    localparam logic [9:0] IDX_DEVCTL   = 10'h01E;
    localparam logic [9:0] IDX_LINKCAP  = 10'h01F;
    localparam logic [9:0] IDX_DEVCAP2  = 10'h025;
    localparam logic [9:0] IDX_AER_HDR  = 10'h040;
    localparam logic [9:0] IDX_DSN_HDR  = 10'h050;
    localparam logic [9:0] IDX_DSN_LO   = 10'h051;
    localparam logic [9:0] IDX_DSN_HI   = 10'h052;
    localparam logic [7:0] PTR_MSI      = 8'h50;
    localparam logic [7:0] PTR_PCIE     = 8'h70;
    localparam logic [11:0] PTR_DSN     = 12'h140;
    localparam logic [7:0] ID_PM        = 8'h01;
    localparam logic [7:0] ID_MSI       = 8'h05;
    localparam logic [7:0] ID_PCIE      = 8'h10;
    localparam logic [15:0] ID_AER      = 16'h0001;
    localparam logic [15:0] ID_DSN      = 16'h0003;
    localparam logic [2:0] MPS_512      = 3'h2;
endpackage

// file: ecs_pwr_sel.sv
// Power figure selector for the power management data register.
// Assumes select and figures come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ecs_pwr_sel
    import ecs_pkg::*;
(
    // Figures, four bytes each, D0 in the low byte
    input  wire logic [31:0] pwr_cons,
    input  wire logic [31:0] pwr_diss,
    // Data select from the status register
    input  wire logic [3:0]  data_sel,
    // Selected figure, zero for unused selects
    output logic      [7:0]  pwr_data
);
    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------
    wire [31:0] bank_w = data_sel[2] ? pwr_diss : pwr_cons;
    wire [7:0]  byte_w = bank_w[8*data_sel[1:0] +: 8];
    // Selects 0-3 consumed, 4-7 dissipated
    assign pwr_data = data_sel[3] ? 8'h00 : byte_w;
endmodule
`default_nettype wire

// file: ecs_rc_model.sv
// Root complex model: issues configuration requests one at a time.
// Assumes the endpoint answers on cfg_cpl or usr_cfg_req within a few cycles of mclk.
`timescale 1ns/1ps
`default_nettype none
module ecs_rc_model
(
    // Clock
    input  wire logic        mclk,
    // Request lines
    output logic             cfg_req,
    output logic             cfg_wr,
    output logic      [9:0]  cfg_idx,
    output logic      [31:0] cfg_wdata,
    // Answer lines
    input  wire logic        cfg_cpl,
    input  wire logic [31:0] cfg_cpl_data,
    input  wire logic        usr_cfg_req
);
    // ------------------------------------------------------------
    // Idle state at time zero
    // ------------------------------------------------------------
    initial begin
        cfg_req = 1'b0;
        cfg_wr = 1'b0;
        cfg_idx = 10'h3FF;
        cfg_wdata = 32'h0000_0000;
    end
    // ------------------------------------------------------------
    // One request, strictly in order, then wait for its answer
    // ------------------------------------------------------------
    task automatic access(input logic w, input logic [9:0] i, input logic [31:0] d,
                          output logic c, output logic f, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        cfg_req <= 1'b1;
        cfg_wr <= w;
        cfg_idx <= i;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_req <= 1'b0;
        cfg_idx <= ~i; // Released lines no longer show the old value
        cfg_wdata <= ~d;
        #1;
        while (cfg_cpl !== 1'b1 && usr_cfg_req !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        c = cfg_cpl;
        f = usr_cfg_req;
        q = cfg_cpl_data;
    endtask
endmodule
`default_nettype wire
